/* File: rtl/nsu_pkg.sv */
// shared constants of the negative-sequence unbalance protection element
package nsu_pkg;
   localparam int          CLK_MHZ      = 50;
   localparam int          ADDR_W       = 8;
   // current scale: nominal current is this code on every phasor input
   localparam int          NOM_CODE     = 4096;
   localparam int          HEAT_SHIFT   = 8;
   localparam int          MAG_W        = 38;
   localparam int          TH_W         = 48;
   // one third, a/3 and a^2/3 parts, Q15
   localparam logic [15:0] C_THIRD      = 16'h2AAB;
   localparam logic [15:0] C_HALF3      = 16'h1555;
   localparam logic [15:0] C_SQRT3      = 16'h24F3;
   localparam int          Q_SHIFT      = 15;
   // thermal state forced to zero below max / this divisor
   localparam logic [6:0]  ZERO_DIV     = 7'h64;
   localparam logic [13:0] PCT_SCALE    = 14'h2710;
   // register byte offsets
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_THRESH   = 8'h04;
   localparam logic [7:0]  OFF_RATIO    = 8'h08;
   localparam logic [7:0]  OFF_DELAY    = 8'h0C;
   localparam logic [7:0]  OFF_KCAP     = 8'h10;
   localparam logic [7:0]  OFF_COOL     = 8'h14;
   localparam logic [7:0]  OFF_STATUS   = 8'h18;
   localparam logic [7:0]  OFF_INT_STAT = 8'h1C;
   localparam logic [7:0]  OFF_INT_MASK = 8'h20;
   localparam logic [7:0]  OFF_THETA    = 8'h24;
   localparam logic [7:0]  OFF_I2SQ     = 8'h28;
   // control bits
   localparam int          CB_ENABLE    = 0;
   localparam int          CB_PH_REV    = 1;
   localparam int          CB_RATIO_EN  = 2;
   localparam int          CB_INVERSE   = 3;
   // interrupt events
   localparam int          EV_PICKUP    = 0;
   localparam int          EV_TRIP      = 1;
   localparam int          EV_COOLED    = 2;
   localparam int          EV_N         = 3;
   typedef enum logic [0:0] {
      NSU_DEFINITE = 1'b0,
      NSU_INVERSE  = 1'b1
   } nsu_char_e;
endpackage : nsu_pkg

/* File: rtl/nsu_seq.sv */
// symmetrical components: squared positive- and negative-sequence magnitudes
`timescale 1ns/1ns
`default_nettype none
module nsu_seq
   import nsu_pkg::*;
(
   // clock and reset
   input  wire  logic                    clk,
   input  wire  logic                    rst_n,
   // phasors, same clock
   input  wire  logic                    eval,
   input  wire  logic                    phase_rev,
   input  wire  logic signed [15:0]      a_re,
   input  wire  logic signed [15:0]      a_im,
   input  wire  logic signed [15:0]      b_re,
   input  wire  logic signed [15:0]      b_im,
   input  wire  logic signed [15:0]      c_re,
   input  wire  logic signed [15:0]      c_im,
   // results
   output logic                          valid,
   output logic        [MAG_W-1:0]       pos_sq,
   output logic        [MAG_W-1:0]       neg_sq
);
   localparam logic signed [16:0] T = {1'b0, C_THIRD};
   localparam logic signed [16:0] H = {1'b0, C_HALF3};
   localparam logic signed [16:0] S = {1'b0, C_SQRT3};

   // |(x + a*y + a^2*z)/3|^2, where a rotates by +120 degrees
   function automatic logic [MAG_W-1:0] comp_sq(
      input logic signed [15:0] xr, input logic signed [15:0] xi,
      input logic signed [15:0] yr, input logic signed [15:0] yi,
      input logic signed [15:0] zr, input logic signed [15:0] zi);
      logic signed [35:0] re;
      logic signed [35:0] im;
      logic signed [18:0] rs;
      logic signed [18:0] is;
      re = 36'(T * xr) - 36'(H * yr) - 36'(S * yi) - 36'(H * zr) + 36'(S * zi);
      im = 36'(T * xi) + 36'(S * yr) - 36'(H * yi) - 36'(S * zr) - 36'(H * zi);
      rs = 19'(re >>> Q_SHIFT);
      is = 19'(im >>> Q_SHIFT);
      comp_sq = MAG_W'(rs * rs) + MAG_W'(is * is);
   endfunction : comp_sq

   // reversed rotation swaps the roles of phases b and c
   wire logic signed [15:0] pb_re = phase_rev ? c_re : b_re;
   wire logic signed [15:0] pb_im = phase_rev ? c_im : b_im;
   wire logic signed [15:0] pc_re = phase_rev ? b_re : c_re;
   wire logic signed [15:0] pc_im = phase_rev ? b_im : c_im;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid  <= 1'b0;
         pos_sq <= '0;
         neg_sq <= '0;
      end else begin
         valid <= eval;
         if (eval) begin
            pos_sq <= comp_sq(a_re, a_im, pb_re, pb_im, pc_re, pc_im);
            neg_sq <= comp_sq(a_re, a_im, pc_re, pc_im, pb_re, pb_im);
         end
      end
   end
endmodule : nsu_seq
`default_nettype wire

/* File: rtl/nsu_therm.sv */
// thermal-energy replica: integrate while heating, exponential decay while cooling
`timescale 1ns/1ns
`default_nettype none
module nsu_therm
   import nsu_pkg::*;
(
   // clock and reset
   input  wire  logic                clk,
   input  wire  logic                rst_n,
   // evaluation
   input  wire  logic                eval,
   input  wire  logic                heating,
   input  wire  logic [MAG_W-1:0]    heat_inc,
   input  wire  logic [31:0]         cool_rate,
   input  wire  logic [TH_W-1:0]     theta_max,
   // state
   output logic       [TH_W-1:0]     theta,
   output logic                      cooled
);
   wire logic [TH_W:0]   sum     = {1'b0, theta} + (TH_W + 1)'(heat_inc);
   wire logic [TH_W-1:0] heated  = sum[TH_W] ? '1 : sum[TH_W-1:0];
   wire logic [79:0]     prod    = 80'(theta) * 80'(cool_rate);
   wire logic [TH_W-1:0] decayed = theta - TH_W'(prod >> 32);
   wire logic [55:0]     scaled  = 56'(decayed) * 56'(ZERO_DIV);
   wire logic            floor   = scaled < 56'(theta_max);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         theta  <= '0;
         cooled <= 1'b0;
      end else begin
         cooled <= 1'b0;
         if (eval) begin
            if (heating) begin
               theta <= heated;
            end else if (theta != '0 && floor) begin
               theta  <= '0;
               cooled <= 1'b1;
            end else begin
               theta <= decayed;
            end
         end
      end
   end

   a_cool_floor: assert property (@(posedge clk) disable iff (!rst_n)
      eval && !heating && theta != '0 && floor |=> theta == '0 && cooled)
      else $error("thermal state not cleared at floor");
   a_heat_grows: assert property (@(posedge clk) disable iff (!rst_n)
      eval && heating |=> theta >= $past(theta))
      else $error("thermal state fell while heating");
endmodule : nsu_therm
`default_nettype wire

/* File: rtl/nsu_top.sv */
// negative-sequence unbalance protection element with apb registers
// What this block does
// - form positive and negative sequence magnitudes from three phase phasors
// - phase reversal control bit swaps which component counts as negative
// - unbalance ratio is i2 over i1 in percent against the ratio pickup
// - condition: i2 above threshold and, if enabled, ratio above pickup
// - trip only after the condition has held for the tripping delay
// - threshold is coded in the same nominal-current scale as the inputs
// - characteristic selects definite delay setting or computed inverse delay
// - definite mode counts ticks while condition holds, trips at the setting
// - thermal state updates every evaluation whatever the trip state or mode
// - inverse mode also needs thermal energy at its maximum from capability
// - from cold, inverse delay is k times in squared over i2 squared minus threshold squared
// - residual heat shortens the inverse delay
// - heating integrates scaled i2 squared minus threshold squared from energy left by cooling
// - heating starts at zero when cooling completed or never happened
// - cooling decays energy exponentially with the cooling time constant
// - decay recomputed every evaluation while i2 stays below threshold
// - below one hundredth of maximum the energy is forced to zero
// - every instance has identical structure, differing only in settings
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module nsu_top
   import nsu_pkg::*;
#(
   parameter int TICK_US     = 1000,
   parameter int TICK_CYCLES = TICK_US * CLK_MHZ
)(
   // clock and reset
   input  wire  logic                 pclk,
   input  wire  logic                 presetn,
   // apb slave
   input  wire  logic [ADDR_W-1:0]    paddr,
   input  wire  logic                 psel,
   input  wire  logic                 penable,
   input  wire  logic                 pwrite,
   input  wire  logic [31:0]          pwdata,
   output logic       [31:0]          prdata,
   output logic                       pready,
   output logic                       pslverr,
   // phase current phasors from the measurement front end
   input  wire  logic signed [15:0]   ph_a_re,
   input  wire  logic signed [15:0]   ph_a_im,
   input  wire  logic signed [15:0]   ph_b_re,
   input  wire  logic signed [15:0]   ph_b_im,
   input  wire  logic signed [15:0]   ph_c_re,
   input  wire  logic signed [15:0]   ph_c_im,
   // decisions
   output logic                       pickup,
   output logic                       trip,
   output logic                       irq
);
   localparam int          TCW       = $clog2(TICK_CYCLES);
   localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
   localparam int          TICKS_PS  = 1000000 / TICK_US;
   // energy per second of nominal negative-sequence current
   localparam logic [TH_W-1:0] IN_SQ_SEC =
      TH_W'(((64'(NOM_CODE) * 64'(NOM_CODE)) >> HEAT_SHIFT) * 64'(TICKS_PS));

   // settings
   logic [3:0]           ctrl_reg;
   logic [15:0]          thresh_reg;
   logic [6:0]           ratio_reg;
   logic [31:0]          delay_reg;
   logic [15:0]          kcap_reg;
   logic [31:0]          cool_reg;
   logic [EV_N-1:0]      istat_reg;
   logic [EV_N-1:0]      imask_reg;
   // datapath state
   logic [TCW-1:0]       tick_cnt_reg;
   logic                 tick_reg;
   logic [31:0]          dcnt_reg;
   logic                 cond_reg;
   logic                 heat_reg;
   logic                 trip_reg;
   logic [TH_W-1:0]      theta_max_reg;
   // apb answer
   logic [31:0]          prdata_reg;
   logic                 pready_reg;
   logic                 pslverr_reg;
   logic                 irq_reg;

   wire logic            seq_valid;
   wire logic [MAG_W-1:0] i1_sq;
   wire logic [MAG_W-1:0] i2_sq;
   wire logic [TH_W-1:0] theta;
   wire logic            cooled;

   // evaluation tick
   wire logic tick_wrap = tick_cnt_reg == TICK_LAST;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1;
         tick_reg     <= tick_wrap;
      end
   end

   // one sequence filter per instance; settings are the only difference
   nsu_seq u_seq (
      .clk       (pclk),
      .rst_n     (presetn),
      .eval      (tick_reg),
      .phase_rev (ctrl_reg[CB_PH_REV]),
      .a_re      (ph_a_re),
      .a_im      (ph_a_im),
      .b_re      (ph_b_re),
      .b_im      (ph_b_im),
      .c_re      (ph_c_re),
      .c_im      (ph_c_im),
      .valid     (seq_valid),
      .pos_sq    (i1_sq),
      .neg_sq    (i2_sq)
   );

   // threshold shares the nominal-current scale of the phasors
   wire logic [MAG_W-1:0] thr_sq   = MAG_W'(32'(thresh_reg) * 32'(thresh_reg));
   wire logic             above    = i2_sq > thr_sq;
   // squared form of i2*100 > pickup*i1 avoids a divider
   wire logic [55:0]      ratio_l  = 56'(i2_sq) * 56'(PCT_SCALE);
   wire logic [55:0]      ratio_r  = 56'(i1_sq) * 56'(14'(ratio_reg) * 14'(ratio_reg));
   wire logic             ratio_ok = !ctrl_reg[CB_RATIO_EN] || ratio_l > ratio_r;
   wire logic             cond_now = ctrl_reg[CB_ENABLE] && above && ratio_ok;
   // heating integrand is i2^2 - threshold^2, so a cold start meets the inverse formula
   wire logic [MAG_W-1:0] heat_inc = above ? (i2_sq - thr_sq) >> HEAT_SHIFT : '0;

   nsu_therm u_therm (
      .clk       (pclk),
      .rst_n     (presetn),
      .eval      (seq_valid),
      .heating   (above),
      .heat_inc  (heat_inc),
      .cool_rate (cool_reg),
      .theta_max (theta_max_reg),
      .theta     (theta),
      .cooled    (cooled)
   );

   wire nsu_char_e char_sel = nsu_char_e'(ctrl_reg[CB_INVERSE]);
   wire logic def_done = dcnt_reg >= delay_reg;
   // residual heat reaches the maximum sooner, shortening the delay
   wire logic inv_done = theta >= theta_max_reg;
   wire logic trip_now = cond_reg && (char_sel == NSU_INVERSE ? inv_done : def_done);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_reg      <= 1'b0;
         heat_reg      <= 1'b0;
         dcnt_reg      <= '0;
         trip_reg      <= 1'b0;
         theta_max_reg <= '0;
      end else begin
         theta_max_reg <= TH_W'(kcap_reg) * IN_SQ_SEC;
         if (seq_valid) begin
            cond_reg <= cond_now;
            heat_reg <= above;
         end
         if (!cond_reg) begin
            dcnt_reg <= '0;
         end else if (tick_reg && !def_done) begin
            dcnt_reg <= dcnt_reg + 1'b1;
         end
         trip_reg <= trip_now;
      end
   end

   // apb decode: one wait-free access cycle after setup
   wire logic setup   = psel && !penable;
   wire logic wr_en   = psel && penable && pwrite && pready_reg;
   wire logic hit_ctrl  = paddr == OFF_CTRL;
   wire logic hit_thr   = paddr == OFF_THRESH;
   wire logic hit_ratio = paddr == OFF_RATIO;
   wire logic hit_delay = paddr == OFF_DELAY;
   wire logic hit_kcap  = paddr == OFF_KCAP;
   wire logic hit_cool  = paddr == OFF_COOL;
   wire logic hit_istat = paddr == OFF_INT_STAT;
   wire logic hit_imask = paddr == OFF_INT_MASK;
   wire logic mapped = hit_ctrl || hit_thr || hit_ratio || hit_delay || hit_kcap
                       || hit_cool || hit_istat || hit_imask || paddr == OFF_STATUS
                       || paddr == OFF_THETA || paddr == OFF_I2SQ;
   wire logic [31:0] status_word = {28'h0000000, char_sel == NSU_INVERSE, heat_reg,
                                    trip_reg, cond_reg};
   wire logic [31:0] rd_mux =
      hit_ctrl              ? 32'(ctrl_reg)   :
      hit_thr               ? 32'(thresh_reg) :
      hit_ratio             ? 32'(ratio_reg)  :
      hit_delay             ? delay_reg       :
      hit_kcap              ? 32'(kcap_reg)   :
      hit_cool              ? cool_reg        :
      paddr == OFF_STATUS   ? status_word     :
      hit_istat             ? 32'(istat_reg)  :
      hit_imask             ? 32'(imask_reg)  :
      paddr == OFF_THETA    ? theta[TH_W-1:TH_W-32] :
      paddr == OFF_I2SQ     ? i2_sq[MAG_W-1:MAG_W-32] :
                              32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= 4'h0;
         thresh_reg <= 16'h0000;
         ratio_reg  <= 7'h00;
         delay_reg  <= 32'h00000000;
         kcap_reg   <= 16'h0000;
         cool_reg   <= 32'h00000000;
         imask_reg  <= '0;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            ctrl_reg <= pwdata[3:0];
         end else if (hit_thr) begin
            thresh_reg <= pwdata[15:0];
         end else if (hit_ratio) begin
            ratio_reg <= pwdata[6:0];
         end else if (hit_delay) begin
            delay_reg <= pwdata;
         end else if (hit_kcap) begin
            kcap_reg <= pwdata[15:0];
         end else if (hit_cool) begin
            cool_reg <= pwdata;
         end else if (hit_imask) begin
            imask_reg <= pwdata[EV_N-1:0];
         end
      end
   end

   // sticky events; a new event wins over a write-one clear in the same cycle
   wire logic [EV_N-1:0] ev;
   assign ev[EV_PICKUP] = cond_now && seq_valid && !cond_reg;
   assign ev[EV_TRIP]   = trip_now && !trip_reg;
   assign ev[EV_COOLED] = cooled;
   wire logic [EV_N-1:0] clr = (wr_en && hit_istat) ? pwdata[EV_N-1:0] : '0;
   wire logic [EV_N-1:0] istat_next = (istat_reg & ~clr) | ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_reg <= '0;
         irq_reg   <= 1'b0;
      end else begin
         istat_reg <= istat_next;
         irq_reg   <= |(istat_next & imask_reg);
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign pickup  = cond_reg;
   assign trip    = trip_reg;
   assign irq     = irq_reg;

   // named steps, each used by one property
   sequence s_cond_held;
      cond_reg && $past(cond_reg);
   endsequence
   sequence s_pick_rise;
      !cond_reg ##1 cond_reg;
   endsequence

   // trip follows the registered condition by one cycle
   a_trip_needs_cond: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_reg) |-> $past(cond_reg))
      else $error("trip without unbalance condition");
   a_trip_drop: assert property (@(posedge pclk) disable iff (!presetn)
      !cond_reg |=> !trip_reg)
      else $error("trip held after dropout");
   a_def_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_reg) && char_sel == NSU_DEFINITE |-> $past(dcnt_reg) >= $past(delay_reg))
      else $error("definite trip before delay");
   a_def_trip: assert property (@(posedge pclk) disable iff (!presetn)
      cond_reg && char_sel == NSU_DEFINITE && def_done |=> trip_reg)
      else $error("definite trip late");
   a_inv_energy: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_reg) && char_sel == NSU_INVERSE |-> $past(theta) >= $past(theta_max_reg))
      else $error("inverse trip below thermal maximum");
   a_inv_trip: assert property (@(posedge pclk) disable iff (!presetn)
      cond_reg && char_sel == NSU_INVERSE && inv_done |=> trip_reg)
      else $error("inverse trip late");

   // delay counter: clear on dropout, step per tick, hold between ticks
   a_dcnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !cond_reg |=> dcnt_reg == '0)
      else $error("delay counter kept value after dropout");
   a_dcnt_step: assert property (@(posedge pclk) disable iff (!presetn)
      s_cond_held ##0 tick_reg && !def_done |=> dcnt_reg == $past(dcnt_reg) + 1)
      else $error("delay counter missed a tick");
   a_dcnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cond_reg && !tick_reg |=> $stable(dcnt_reg))
      else $error("delay counter moved between ticks");

   // pickup gated by threshold, ratio and enable; evaluation tick spacing and phase
   a_cond_gate: assert property (@(posedge pclk) disable iff (!presetn)
      seq_valid && !above |=> !cond_reg)
      else $error("pickup below threshold");
   a_ratio_gate: assert property (@(posedge pclk) disable iff (!presetn)
      seq_valid && ctrl_reg[CB_RATIO_EN] && ratio_l <= ratio_r |=> !cond_reg)
      else $error("pickup below ratio");
   a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
      seq_valid && !ctrl_reg[CB_ENABLE] |=> !cond_reg)
      else $error("pickup while disabled");
   a_tick_space: assert property (@(posedge pclk) disable iff (!presetn)
      tick_reg |=> !tick_reg)
      else $error("evaluation tick longer than a cycle");
   a_tick_phase: assert property (@(posedge pclk) disable iff (!presetn)
      tick_reg |-> tick_cnt_reg == '0)
      else $error("tick out of phase with counter");

   // bus answer and sticky events
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready_reg && (pslverr_reg == !$past(mapped)))
      else $error("apb access not answered next cycle");
   a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr_reg |-> pready_reg)
      else $error("error without ready");
   a_wr_zero: assert property (@(posedge pclk) disable iff (!presetn)
      setup && pwrite |=> prdata_reg == 32'h00000000)
      else $error("write returned read data");
   a_pick_event: assert property (@(posedge pclk) disable iff (!presetn)
      s_pick_rise |-> istat_reg[EV_PICKUP])
      else $error("pickup rise not latched");
   a_ev_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (|ev) |=> (istat_reg & $past(ev)) == $past(ev))
      else $error("event lost to clear");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq_reg == |($past(istat_next) & $past(imask_reg)))
      else $error("interrupt level mismatch");
endmodule : nsu_top
`default_nettype wire

/* File: tb/nsu_front.sv */
// three-phase current source model driven by wanted sequence magnitudes
`timescale 1ns/1ns
`default_nettype none
module nsu_front (
   // clock
   input  wire logic          clk,
   // sequence magnitudes, both at angle zero
   input  wire logic [15:0]   pos_mag,
   input  wire logic [15:0]   neg_mag,
   // phase phasors, rotation a-b-c
   output logic signed [15:0] a_re,
   output logic signed [15:0] a_im,
   output logic signed [15:0] b_re,
   output logic signed [15:0] b_im,
   output logic signed [15:0] c_re,
   output logic signed [15:0] c_im
);
   // sin of 120 degrees, q15
   localparam int S120 = 28378;
   int s;
   int d;
   always_comb s = int'(pos_mag) + int'(neg_mag);
   always_comb d = ((int'(neg_mag) - int'(pos_mag)) * S120) >>> 15;
   // registered so the phasors move only just after an edge
   always_ff @(posedge clk) begin
      a_re <= 16'(s);
      a_im <= 16'h0000;
      b_re <= 16'(-s / 2);
      b_im <= 16'(d);
      c_re <= 16'(-s / 2);
      c_im <= 16'(-d);
   end
endmodule : nsu_front
`default_nettype wire

/* File: tb/tb_nsu_top.sv */
// self-checking bench of the unbalance protection element
`timescale 1ns/1ns
`default_nettype none
module tb_nsu_top
   import nsu_pkg::*;
;
   // short tick keeps every delay under two hundred cycles
   localparam int TK = 16;
   logic               pclk, presetn, psel, penable, pwrite;
   logic        [7:0]  paddr;
   logic        [31:0] pwdata, prdata, rd_v;
   logic               pready, pslverr, er_v, pickup, trip, irq;
   logic        [15:0] pos_mag, neg_mag;
   logic signed [15:0] a_re, a_im, b_re, b_im, c_re, c_im;
   int                 miscompares, comparisons, cnt, rv, i1, i2, thr, pct, ren, e;

   nsu_top #(.TICK_US(100000), .TICK_CYCLES(TK)) nsu_top_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ph_a_re(a_re), .ph_a_im(a_im),
      .ph_b_re(b_re), .ph_b_im(b_im), .ph_c_re(c_re), .ph_c_im(c_im), .pickup(pickup),
      .trip(trip), .irq(irq));
   nsu_front nsu_front_i (.clk(pclk), .pos_mag(pos_mag), .neg_mag(neg_mag), .a_re(a_re),
      .a_im(a_im), .b_re(b_re), .b_im(b_im), .c_re(c_re), .c_im(c_im));

   always #10 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v    = prdata;
      er_v    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd_v, exp);
   endtask : rd_chk

   task automatic feed(input int p, input int n);
      @(posedge pclk);
      pos_mag <= 16'(p);
      neg_mag <= 16'(n);
   endtask : feed

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   // cycles from now until trip, capped
   task automatic time_trip();
      cnt = 0;
      while (trip !== 1'b1 && cnt < 1000) begin
         @(posedge pclk);
         cnt++;
      end
   endtask : time_trip

   // 2 means too close to a boundary for the fixed-point magnitudes
   function automatic int exp_pick(int a1, int a2, int t, int p, int r);
      real a, tt, x, q;
      a  = real'(a2) * a2;
      tt = real'(t) * t;
      x  = a * 10000.0;
      q  = real'(p) * p * a1 * a1;
      if ((a < tt * 1.1 && a > tt * 0.9) || (r != 0 && x < q * 1.1 && x > q * 0.9)) return 2;
      return int'(a > tt && (r == 0 || x > q));
   endfunction : exp_pick

   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      conclude();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pos_mag, neg_mag} = '0;
      rv = $urandom(32'h9c4b0e17);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFF_CTRL, 32'h0);
      rd_chk(OFF_THETA, 32'h0);
      apb(1'b0, 8'hFC, 32'h0);
      check({31'h0, er_v}, 32'h1);
      wr(OFF_RATIO, 32'hFFFFFFFF);
      rd_chk(OFF_RATIO, 32'h7F);
      $display("test registers done");
      wr(OFF_DELAY, 32'hFFFF);
      for (int k = 0; k < 8; k++) begin
         i1 = 2048 + $urandom % 2048;
         i2 = $urandom % 2048;
         thr = 100 + $urandom % 1000;
         pct = 5 + $urandom % 60;
         ren = $urandom % 2;
         wr(OFF_THRESH, 32'(thr));
         wr(OFF_RATIO, 32'(pct));
         wr(OFF_CTRL, 32'(1 | (ren << CB_RATIO_EN)));
         feed(i1, i2);
         repeat (3 * TK) @(posedge pclk);
         e = exp_pick(i1, i2, thr, pct, ren);
         if (e != 2) check({31'h0, pickup}, 32'(e));
      end
      $display("test random pickup done");
      wr(OFF_INT_STAT, 32'h7);
      wr(OFF_THRESH, 32'd2048);
      wr(OFF_CTRL, 32'h1);
      feed(4096, 0);
      repeat (3 * TK) @(posedge pclk);
      check({31'h0, pickup}, 32'h0);
      wr(OFF_CTRL, 32'h3);
      repeat (3 * TK) @(posedge pclk);
      check({31'h0, pickup}, 32'h1);
      check({31'h0, irq}, 32'h0);
      apb(1'b0, OFF_INT_STAT, 32'h0);
      check(rd_v & 32'h1, 32'h1);
      $display("test phase order done");
      wr(OFF_CTRL, 32'h1);
      wr(OFF_THRESH, 32'd1024);
      wr(OFF_DELAY, 32'd5);
      wr(OFF_INT_MASK, 32'h3);
      repeat (2 * TK) @(posedge pclk);
      wr(OFF_INT_STAT, 32'h7);
      feed(4096, 2048);
      time_trip();
      check(32'(cnt >= 5 * TK && cnt <= 7 * TK), 32'h1);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      rd_chk(OFF_INT_STAT, 32'h3);
      rd_chk(OFF_STATUS, 32'h7);
      wr(OFF_INT_STAT, 32'h3);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      feed(4096, 0);
      repeat (2 * TK) @(posedge pclk);
      check({30'h0, trip, pickup}, 32'h0);
      $display("test definite delay done");
      // second reset clears the heat built up so far
      do_reset();
      wr(OFF_KCAP, 32'h1);
      wr(OFF_THRESH, 32'h0);
      feed(0, 4096);
      repeat (3 * TK) @(posedge pclk);
      apb(1'b0, OFF_THETA, 32'h0);
      check(32'(rd_v != 0), 32'h1);
      apb(1'b0, OFF_I2SQ, 32'h0);
      check(32'(rd_v > 32'h3F000 && rd_v <= 32'h40000), 32'h1);
      wr(OFF_COOL, 32'h80000000);
      feed(0, 0);
      repeat (12 * TK) @(posedge pclk);
      rd_chk(OFF_THETA, 32'h0);
      apb(1'b0, OFF_INT_STAT, 32'h0);
      check(rd_v & 32'h4, 32'h4);
      wr(OFF_CTRL, 32'h9);
      feed(0, 4096);
      time_trip();
      check(32'(cnt >= 9 * TK && cnt <= 12 * TK), 32'h1);
      feed(0, 0);
      repeat (TK - 1) @(posedge pclk);
      feed(0, 4096);
      time_trip();
      check(32'(cnt >= 4 * TK && cnt <= 8 * TK), 32'h1);
      $display("test inverse delay done");
      conclude();
   end
endmodule : tb_nsu_top
`default_nettype wire
